/* include/svtd_pkg.sv */
// Package with constants, types and register map of the status and valve timer display block.
package svtd_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ONTIME = 8'h04;
  localparam logic [7:0] ADDR_DWELL = 8'h08;
  localparam logic [7:0] ADDR_REMOTE = 8'h0C;
  localparam int REMOTE_STOP_BIT = 0;
  localparam int REMOTE_START_BIT = 1;
  localparam int ONTIME_MIN_LSB = 0;
  localparam int ONTIME_HRS_LSB = 8;
  localparam int ONTIME_DAY_LSB = 16;
  localparam int STATUS_MSG_LSB = 0;
  localparam int STATUS_FLAG_LSB = 8;
  localparam int STATUS_SEQ_LSB = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SEL_HOLD_S = 5;
  localparam int unsigned CLR_HOLD_S = 4;
  localparam int unsigned MINUTE_S = 60;
  localparam int unsigned STARTUP_S = 2;
  localparam int unsigned DWELL_MS = 1000;
  localparam int unsigned SEL_HOLD_CYC = SEL_HOLD_S * CLK_HZ;
  localparam int unsigned CLR_HOLD_CYC = CLR_HOLD_S * CLK_HZ;
  localparam int unsigned MINUTE_CYC = MINUTE_S * CLK_HZ;
  localparam int unsigned STARTUP_CYC = STARTUP_S * CLK_HZ;
  localparam logic [31:0] DWELL_RST = 32'(DWELL_MS * (CLK_HZ / 1000));

  // ****************************************************************
  // On-time limits
  // ****************************************************************
  localparam logic [13:0] DAYS_MAX = 14'd9999;
  localparam logic [4:0] HOURS_MAX = 5'd23;
  localparam logic [5:0] MINS_MAX = 6'd59;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [4:0] {
    MSG_TEMP, MSG_LOW_LEVEL, MSG_SD, MSG_POC, MSG_HE, MSG_RSP, MSG_TC_DIS, MSG_OPEN,
    MSG_UNCAL, MSG_PILF, MSG_SFP, MSG_SF2, MSG_SF3, MSG_FE1, MSG_ER1, MSG_ER2, MSG_ER12,
    MSG_SOL, MSG_TIME_ON, MSG_DAYS_VAL, MSG_DAYS_LBL, MSG_HRS_VAL, MSG_HRS_LBL,
    MSG_MIN_VAL, MSG_MIN_LBL, MSG_RESET
  } svtd_msg_t;

  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_SOL, SEQ_TON, SEQ_DVAL, SEQ_DLBL, SEQ_HVAL, SEQ_HLBL, SEQ_MVAL,
    SEQ_MLBL, SEQ_CSOL, SEQ_RST
  } svtd_seq_t;

  typedef struct packed {
    logic low_level_open;
    logic shutdown_open;
    logic closure_proof_input;
    logic limit_at_setpoint;
    logic process_tc_open;
    logic limit_tc_open;
    logic process_tc_fault;
    logic cal_absent;
    logic cal_bad_process;
    logic cal_bad_limit;
    logic onoff_switch;
    logic remote_onoff;
  } svtd_field_t;

  typedef struct packed {
    logic pilot_sensed;
    logic pilot_short;
    logic main_short;
    logic tmain_short;
  } svtd_monitor_t;

  typedef struct packed {
    logic pilot_req;
    logic main_req;
    logic tmain_req;
  } svtd_demand_t;

  typedef struct packed {
    logic overtemp_latch_option;
    logic continuous_pilot_option;
    logic limit_sensor_enable_switch;
    logic limit_selected;
  } svtd_option_t;

  typedef struct packed {
    logic sel_btn;
    logic down_btn;
  } svtd_keys_t;

  typedef struct packed {
    logic pilot;
    logic main;
    logic tmain;
    logic ignition;
  } svtd_drive_t;

  typedef struct packed {
    logic [13:0] days;
    logic [4:0] hours;
    logic [5:0] mins;
  } svtd_ontime_t;

  typedef struct packed {
    svtd_msg_t msg;
    logic [13:0] value;
  } svtd_disp_t;

endpackage : svtd_pkg

/* hdl/svtd_core.sv */
// Status message selection, interlock gating and valve on-time sequencer with AHB-Lite registers.
`timescale 1ns/10ps
`default_nettype none
module svtd_core #(
  parameter int unsigned SEL_HOLD_CYC = svtd_pkg::SEL_HOLD_CYC,
  parameter int unsigned CLR_HOLD_CYC = svtd_pkg::CLR_HOLD_CYC,
  parameter int unsigned MINUTE_CYC = svtd_pkg::MINUTE_CYC,
  parameter int unsigned STARTUP_CYC = svtd_pkg::STARTUP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire svtd_pkg::svtd_field_t field,
  input wire svtd_pkg::svtd_monitor_t monitor,
  input wire svtd_pkg::svtd_demand_t demand,
  input wire svtd_pkg::svtd_option_t option,
  input wire svtd_pkg::svtd_keys_t keys,
  output svtd_pkg::svtd_drive_t drive,
  output svtd_pkg::svtd_disp_t disp
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  // A zero count would wrap its compare value and never match, so small counts are refused.
  if (SEL_HOLD_CYC < 2) begin : g_chk_sel
    $error("svtd_core: SEL_HOLD_CYC must be at least 2");
  end
  if (CLR_HOLD_CYC < 2) begin : g_chk_clr
    $error("svtd_core: CLR_HOLD_CYC must be at least 2");
  end
  if (MINUTE_CYC < 2) begin : g_chk_min
    $error("svtd_core: MINUTE_CYC must be at least 2");
  end
  if (STARTUP_CYC < 2) begin : g_chk_start
    $error("svtd_core: STARTUP_CYC must be at least 2");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    svtd_pkg::svtd_seq_t seq;
    logic [31:0] seq_cnt;
    logic [31:0] hold_cnt;
    logic [31:0] clr_cnt;
    logic armed;
    logic [31:0] min_cnt;
    svtd_pkg::svtd_ontime_t ontime;
    logic he_latch;
    logic stop;
    logic sw_prev;
    logic rsw_prev;
    logic startup;
    logic [31:0] startup_cnt;
    svtd_pkg::svtd_disp_t disp;
    svtd_pkg::svtd_drive_t drive;
    logic [31:0] dwell;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } svtd_state_t;

  svtd_state_t s_q;
  svtd_state_t s_d;

  logic addr_ok;
  logic toggle;
  logic he_now;
  logic he_active;
  logic tc_open;
  logic fe1;
  logic start_ok;
  logic pilf;
  logic dwell_done;
  logic tick;
  logic clear_now;
  logic stop_cmd;
  logic start_cmd;
  logic [31:0] dwell_lim;
  svtd_pkg::svtd_msg_t msg_n;
  logic [13:0] val_n;
  logic [31:0] rmux;

  // Every register answers at once, so the slave never stretches a transfer.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign drive = s_q.drive;
  assign disp = s_q.disp;

  always_comb begin
    s_d = s_q;
    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Every transfer completes in one data-phase cycle, so write data is applied
    // the cycle after the address phase and read data is latched at the address phase.
    addr_ok = hsel & htrans[1] & hready;
    stop_cmd = s_q.wr_pend & (s_q.wr_addr == svtd_pkg::ADDR_REMOTE) &
               hwdata[svtd_pkg::REMOTE_STOP_BIT];
    start_cmd = s_q.wr_pend & (s_q.wr_addr == svtd_pkg::ADDR_REMOTE) &
                hwdata[svtd_pkg::REMOTE_START_BIT];
    // A new dwell applies to the message already showing, from its next cycle.
    if (s_q.wr_pend && s_q.wr_addr == svtd_pkg::ADDR_DWELL) begin
      s_d.dwell = hwdata;
    end
    s_d.wr_pend = addr_ok & hwrite;
    s_d.wr_addr = haddr[7:0];
    rmux = 32'h0000_0000;
    case (haddr[7:0])
      svtd_pkg::ADDR_STATUS: begin
        rmux[svtd_pkg::STATUS_MSG_LSB +: 5] = s_q.disp.msg;
        rmux[svtd_pkg::STATUS_FLAG_LSB +: 7] = {s_q.startup, s_q.stop, s_q.he_latch,
                                                 s_q.drive.ignition, s_q.drive.tmain,
                                                 s_q.drive.main, s_q.drive.pilot};
        rmux[svtd_pkg::STATUS_SEQ_LSB +: 4] = s_q.seq;
      end
      svtd_pkg::ADDR_ONTIME: begin
        rmux[svtd_pkg::ONTIME_MIN_LSB +: 6] = s_q.ontime.mins;
        rmux[svtd_pkg::ONTIME_HRS_LSB +: 5] = s_q.ontime.hours;
        rmux[svtd_pkg::ONTIME_DAY_LSB +: 14] = s_q.ontime.days;
      end
      svtd_pkg::ADDR_DWELL: begin
        rmux = s_q.dwell;
      end
      // The remote register is write-only, so it reads as zero like any unmapped offset.
      default: begin
        rmux = 32'h0000_0000;
      end
    endcase
    if (addr_ok && !hwrite) begin
      s_d.rdata = rmux;
    end

    // ****************************************************************
    // Interlocks and latches
    // ****************************************************************
    // A return of either switch to On, or any remote command, counts as a toggle.
    toggle = (field.onoff_switch & ~s_q.sw_prev) | (field.remote_onoff & ~s_q.rsw_prev) |
             stop_cmd | start_cmd;
    s_d.sw_prev = field.onoff_switch;
    s_d.rsw_prev = field.remote_onoff;
    he_now = field.limit_at_setpoint;
    // Set wins over a toggle in the same cycle, so a live overtemperature is never cleared.
    if (he_now && option.overtemp_latch_option) begin
      s_d.he_latch = 1'b1;
    end else if (toggle) begin
      s_d.he_latch = 1'b0;
    end
    he_active = he_now | s_q.he_latch;
    // A stop written with a start keeps the burner stopped; the safe request wins.
    if (stop_cmd) begin
      s_d.stop = 1'b1;
    end else if (start_cmd || toggle) begin
      s_d.stop = 1'b0;
    end
    tc_open = field.process_tc_open | field.limit_tc_open;
    fe1 = option.continuous_pilot_option & field.process_tc_fault;
    // Whatever blocks a start also removes ignition power and every valve.
    start_ok = field.onoff_switch & field.remote_onoff & ~s_q.stop & ~field.low_level_open &
               ~field.shutdown_open & field.closure_proof_input & ~tc_open;
    s_d.drive.ignition = start_ok & ~fe1;
    s_d.drive.pilot = start_ok & ~fe1 & ~he_active & demand.pilot_req;
    s_d.drive.main = start_ok & ~fe1 & ~he_active & demand.main_req;
    s_d.drive.tmain = start_ok & ~fe1 & ~he_active & demand.tmain_req;
    // The monitor follows the registered drive, so both sides of the compare are aligned.
    pilf = s_q.drive.pilot & ~monitor.pilot_sensed;
    // The startup window opens once per reset, the only time the uncalibrated warning shows.
    if (s_q.startup) begin
      s_d.startup_cnt = s_q.startup_cnt + 32'd1;
      if (s_q.startup_cnt == 32'(STARTUP_CYC - 1)) begin
        s_d.startup = 1'b0;
      end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // A zero dwell would make every message vanish; it is served as one cycle.
    dwell_lim = (s_q.dwell == 32'd0) ? 32'd0 : s_q.dwell - 32'd1;
    dwell_done = s_q.seq_cnt >= dwell_lim;
    clear_now = 1'b0;
    s_d.seq_cnt = s_q.seq_cnt + 32'd1;
    // The dwell counter saturates so a huge dwell cannot wrap and cut a message short.
    if (s_q.seq_cnt == 32'hFFFF_FFFF) begin
      s_d.seq_cnt = s_q.seq_cnt;
    end
    case (s_q.seq)
      svtd_pkg::SEQ_IDLE: begin
        s_d.clr_cnt = 32'd0;
        // Select must be seen released first, so a key stuck at reset starts nothing.
        if (!keys.sel_btn) begin
          s_d.armed = 1'b1;
          s_d.hold_cnt = 32'd0;
        end else if (s_q.armed) begin
          s_d.hold_cnt = s_q.hold_cnt + 32'd1;
          if (s_q.hold_cnt == 32'(SEL_HOLD_CYC - 1)) begin
            s_d.seq = svtd_pkg::SEQ_SOL;
            s_d.seq_cnt = 32'd0;
            s_d.armed = 1'b0;
          end
        end
      end
      svtd_pkg::SEQ_SOL: begin
        // SOL stays up while select is held so the clear gesture has time to finish.
        s_d.seq_cnt = keys.sel_btn ? 32'd0 : s_d.seq_cnt;
        if (keys.sel_btn && keys.down_btn) begin
          s_d.clr_cnt = s_q.clr_cnt + 32'd1;
          if (s_q.clr_cnt == 32'(CLR_HOLD_CYC - 1)) begin
            clear_now = 1'b1;
            s_d.seq = svtd_pkg::SEQ_CSOL;
            s_d.seq_cnt = 32'd0;
          end
        end else begin
          s_d.clr_cnt = 32'd0;
          if (!keys.sel_btn && dwell_done) begin
            s_d.seq = svtd_pkg::SEQ_TON;
            s_d.seq_cnt = 32'd0;
          end
        end
      end
      // States are declared in display order, so each step is the next code.
      svtd_pkg::SEQ_TON, svtd_pkg::SEQ_DVAL, svtd_pkg::SEQ_DLBL, svtd_pkg::SEQ_HVAL,
      svtd_pkg::SEQ_HLBL, svtd_pkg::SEQ_MVAL, svtd_pkg::SEQ_CSOL: begin
        if (dwell_done) begin
          s_d.seq = svtd_pkg::svtd_seq_t'(s_q.seq + 4'd1);
          s_d.seq_cnt = 32'd0;
        end
      end
      svtd_pkg::SEQ_MLBL, svtd_pkg::SEQ_RST: begin
        if (dwell_done) begin
          s_d.seq = svtd_pkg::SEQ_IDLE;
          s_d.seq_cnt = 32'd0;
          s_d.hold_cnt = 32'd0;
        end
      end
      default: begin
        s_d.seq = svtd_pkg::SEQ_IDLE;
      end
    endcase

    // ****************************************************************
    // On-time accumulator
    // ****************************************************************
    // The minute prescaler keeps its count while the valve is off, so short burns add up.
    tick = 1'b0;
    if (s_q.drive.tmain) begin
      s_d.min_cnt = s_q.min_cnt + 32'd1;
      if (s_q.min_cnt == 32'(MINUTE_CYC - 1)) begin
        s_d.min_cnt = 32'd0;
        tick = 1'b1;
      end
    end
    // At the ceiling the count holds rather than wrap, so a worn valve never reads as new.
    if (clear_now) begin
      s_d.ontime = '0;
      s_d.min_cnt = 32'd0;
    end else if (tick && !(s_q.ontime.days == svtd_pkg::DAYS_MAX &&
                           s_q.ontime.hours == svtd_pkg::HOURS_MAX &&
                           s_q.ontime.mins == svtd_pkg::MINS_MAX)) begin
      if (s_q.ontime.mins != svtd_pkg::MINS_MAX) begin
        s_d.ontime.mins = s_q.ontime.mins + 6'd1;
      end else begin
        s_d.ontime.mins = 6'd0;
        if (s_q.ontime.hours != svtd_pkg::HOURS_MAX) begin
          s_d.ontime.hours = s_q.ontime.hours + 5'd1;
        end else begin
          s_d.ontime.hours = 5'd0;
          s_d.ontime.days = s_q.ontime.days + 14'd1;
        end
      end
    end

    // ****************************************************************
    // Message selection
    // ****************************************************************
    // Safety faults outrank status; calibration warnings replace only the temperature, except MSG_UNCAL, which also outranks MSG_TC_DIS.
    val_n = 14'd0;
    case (s_q.seq)
      svtd_pkg::SEQ_SOL, svtd_pkg::SEQ_CSOL: msg_n = svtd_pkg::MSG_SOL;
      svtd_pkg::SEQ_TON: msg_n = svtd_pkg::MSG_TIME_ON;
      svtd_pkg::SEQ_DVAL: begin
        msg_n = svtd_pkg::MSG_DAYS_VAL;
        val_n = s_q.ontime.days;
      end
      svtd_pkg::SEQ_DLBL: msg_n = svtd_pkg::MSG_DAYS_LBL;
      svtd_pkg::SEQ_HVAL: begin
        msg_n = svtd_pkg::MSG_HRS_VAL;
        val_n = {9'd0, s_q.ontime.hours};
      end
      svtd_pkg::SEQ_HLBL: msg_n = svtd_pkg::MSG_HRS_LBL;
      svtd_pkg::SEQ_MVAL: begin
        msg_n = svtd_pkg::MSG_MIN_VAL;
        val_n = {8'd0, s_q.ontime.mins};
      end
      svtd_pkg::SEQ_MLBL: msg_n = svtd_pkg::MSG_MIN_LBL;
      svtd_pkg::SEQ_RST: msg_n = svtd_pkg::MSG_RESET;
      default: begin
        if (tc_open) msg_n = svtd_pkg::MSG_OPEN;
        else if (monitor.pilot_short) msg_n = svtd_pkg::MSG_SFP;
        else if (monitor.main_short) msg_n = svtd_pkg::MSG_SF2;
        else if (monitor.tmain_short) msg_n = svtd_pkg::MSG_SF3;
        else if (pilf) msg_n = svtd_pkg::MSG_PILF;
        else if (fe1) msg_n = svtd_pkg::MSG_FE1;
        else if (!field.closure_proof_input) msg_n = svtd_pkg::MSG_POC;
        else if (field.shutdown_open) msg_n = svtd_pkg::MSG_SD;
        else if (field.low_level_open) msg_n = svtd_pkg::MSG_LOW_LEVEL;
        else if (he_active) msg_n = svtd_pkg::MSG_HE;
        else if (s_q.stop) msg_n = svtd_pkg::MSG_RSP;
        else if (s_q.startup && field.cal_absent) msg_n = svtd_pkg::MSG_UNCAL;
        else if (option.limit_selected && !option.limit_sensor_enable_switch) begin
          msg_n = svtd_pkg::MSG_TC_DIS;
        end
        else if (field.cal_bad_process && field.cal_bad_limit) begin
          msg_n = svtd_pkg::MSG_ER12;
        end
        else if (field.cal_bad_process) msg_n = svtd_pkg::MSG_ER1;
        else if (field.cal_bad_limit) msg_n = svtd_pkg::MSG_ER2;
        else msg_n = svtd_pkg::MSG_TEMP;
      end
    endcase
    s_d.disp.msg = msg_n;
    s_d.disp.value = val_n;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.seq <= svtd_pkg::SEQ_IDLE;
      s_q.startup <= 1'b1;
      // Switch history starts at On, so switches already on at release are no toggle.
      s_q.sw_prev <= 1'b1;
      s_q.rsw_prev <= 1'b1;
      s_q.dwell <= svtd_pkg::DWELL_RST;
      s_q.disp.msg <= svtd_pkg::MSG_TEMP;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : svtd_core
`default_nettype wire

/* test/svtd_valve_model.sv */
// Behavioural model of the solenoid output monitors at the far side.
`timescale 1ns/10ps
`default_nettype none
module svtd_valve_model (
  input wire svtd_pkg::svtd_drive_t drive,
  input wire logic [3:0] fault,
  output svtd_pkg::svtd_monitor_t monitor
);
  // ****************************************************************
  // Monitors
  // ****************************************************************
  // Shorts come from the fault inputs alone, so a short on an idle output is still reported.
  assign monitor.pilot_sensed = drive.pilot & ~fault[3];
  assign monitor.pilot_short = fault[2];
  assign monitor.main_short = fault[1];
  assign monitor.tmain_short = fault[0];
endmodule : svtd_valve_model
`default_nettype wire

/* test/svtd_core_assertions.sv */
// Concurrent checks on the ports of the status and valve timer display core.
`timescale 1ns/10ps
`default_nettype none
module svtd_core_assertions #(
  parameter int unsigned SEL_HOLD_CYC = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire svtd_pkg::svtd_field_t field,
  input wire svtd_pkg::svtd_option_t option,
  input wire svtd_pkg::svtd_keys_t keys,
  input wire svtd_pkg::svtd_drive_t drive,
  input wire svtd_pkg::svtd_disp_t disp
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic [31:0] sel_cnt_d;
  logic [31:0] sel_cnt_q;
  logic tc_open;
  logic valves;
  assign tc_open = field.process_tc_open | field.limit_tc_open;
  assign valves = drive.pilot | drive.main | drive.tmain;
  always_comb begin
    sel_cnt_d = keys.sel_btn ? sel_cnt_q + 32'd1 : 32'd0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_cnt_q <= 32'd0;
    end else begin
      sel_cnt_q <= sel_cnt_d;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_step;
    $changed(disp.msg) && $past(disp.msg) inside
      {[svtd_pkg::MSG_TIME_ON:svtd_pkg::MSG_MIN_VAL]};
  endsequence
  sequence s_sol_entry;
    $changed(disp.msg) && disp.msg == svtd_pkg::MSG_SOL && $past(disp.msg) < svtd_pkg::MSG_SOL;
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  chk_open_valves: assert property ($past(tc_open) |-> !valves)
    else $error("valve open with sensor open");
  chk_open_msg: assert property ($past(tc_open) && disp.msg < svtd_pkg::MSG_SOL |->
    disp.msg == svtd_pkg::MSG_OPEN) else $error("open sensor not shown");
  chk_poc_ignition: assert property ($past(!field.closure_proof_input) |-> !drive.ignition)
    else $error("ignition on without closure proof");
  chk_he_valves: assert property ($past(field.limit_at_setpoint) |-> !valves)
    else $error("valve open at limit setpoint");
  chk_fe1_ignition: assert property ($past(option.continuous_pilot_option &&
    field.process_tc_fault) |-> !drive.ignition) else $error("ignition on with process fault");
  chk_ign_cause: assert property ($rose(drive.ignition) |-> $past(field.onoff_switch &&
    field.remote_onoff && !field.low_level_open && !field.shutdown_open))
    else $error("ignition started while stopped");
  chk_value_zero: assert property (!(disp.msg inside {svtd_pkg::MSG_DAYS_VAL,
    svtd_pkg::MSG_HRS_VAL, svtd_pkg::MSG_MIN_VAL}) |-> disp.value == 14'd0)
    else $error("value shown with a label");
  chk_seq_order: assert property (s_step |->
    5'(disp.msg) == 5'($past(disp.msg)) + 5'd1) else $error("sequence out of order");
  chk_sol_hold: assert property (s_sol_entry |-> sel_cnt_q >= SEL_HOLD_CYC - 1)
    else $error("sequence began before the hold time");
  chk_reset_after: assert property ($changed(disp.msg) && disp.msg == svtd_pkg::MSG_RESET |->
    $past(disp.msg) == svtd_pkg::MSG_SOL) else $error("reset message not after SOL");
endmodule : svtd_core_assertions
bind svtd_core svtd_core_assertions #(.SEL_HOLD_CYC(SEL_HOLD_CYC)) chk_u (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .field(field), .option(option),
  .keys(keys), .drive(drive), .disp(disp));
`default_nettype wire

/* test/svtd_core_bench.sv */
// Self-checking bench for the status and valve timer display core.
`timescale 1ns/10ps
`default_nettype none
module svtd_core_bench;
  localparam int SEL = 20;
  localparam int CLR = 16;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'd2;
  logic [31:0] hwdata = '0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] fault = '0;
  svtd_pkg::svtd_field_t field = 12'h213;
  svtd_pkg::svtd_monitor_t monitor;
  svtd_pkg::svtd_demand_t demand = 3'b110;
  svtd_pkg::svtd_option_t option = 4'b0010;
  svtd_pkg::svtd_keys_t keys = 2'b00;
  svtd_pkg::svtd_drive_t drive;
  svtd_pkg::svtd_disp_t disp;
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  logic [31:0] rd;
  logic [11:0] tf [16] = '{12'hA03, 12'h603, 12'h403, 12'h303, 12'h283, 12'h243, 12'h20B,
    12'h207, 12'h20F, 12'h223, 12'h203, 12'h203, 12'h203, 12'h203, 12'h203, 12'h203};
  logic [3:0] to [16] = '{2, 2, 2, 2, 2, 2, 2, 2, 2, 6, 1, 2, 2, 2, 2, 2};
  logic [3:0] tq [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8, 4, 2, 1, 0};
  logic [3:0] td [16] = '{0, 0, 0, 1, 0, 0, 13, 13, 13, 0, 13, 13, 13, 13, 13, 13};
  logic [4:0] tm [16] = '{1, 2, 3, 4, 7, 7, 14, 15, 16, 13, 6, 9, 10, 11, 12, 0};
  logic [13:0] sv [7] = '{0, 1, 0, 0, 0, 3, 0};
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  svtd_core #(.SEL_HOLD_CYC(SEL), .CLR_HOLD_CYC(CLR), .MINUTE_CYC(10), .STARTUP_CYC(50)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .field(field), .monitor(monitor), .demand(demand),
    .option(option), .keys(keys), .drive(drive), .disp(disp));
  svtd_valve_model pm_u (.drive(drive), .fault(fault), .monitor(monitor));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic tick(input int c);
    repeat (c) @(posedge hclk);
    #1;
  endtask : tick
  // The address phase is held until hready, then the data phase until hready again.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic setf(input logic [11:0] f, input logic [3:0] o, input logic [3:0] q);
    @(posedge hclk);
    field <= f;
    option <= o;
    fault <= q;
    tick(3);
  endtask : setf
  task automatic wait_msg(input svtd_pkg::svtd_msg_t m, input int lim);
    n = 0;
    while (disp.msg !== m && n < lim) begin
      tick(1);
      n++;
    end
    check(32'(disp.msg), 32'(m));
  endtask : wait_msg
  task automatic hold_sel();
    @(posedge hclk);
    keys <= 2'b10;
    wait_msg(svtd_pkg::MSG_SOL, SEL + 5);
    check(32'(n >= SEL && n <= SEL + 2), 32'd1);
    @(posedge hclk);
  endtask : hold_sel
  task automatic run_tmain(input int c);
    @(posedge hclk);
    demand <= 3'b111;
    repeat (c) @(posedge hclk);
    demand <= 3'b110;
    tick(3);
  endtask : run_tmain
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #4_000_000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    tick(3);
    check(32'(disp.msg), 32'(svtd_pkg::MSG_UNCAL));
    ahb(1'b0, svtd_pkg::ADDR_STATUS, 0);
    check(32'(rd[14]), 32'd1);
    ahb(1'b0, svtd_pkg::ADDR_ONTIME, 0);
    check(rd, 32'h0000_0000);
    ahb(1'b1, svtd_pkg::ADDR_DWELL, 32'h0000_0004);
    ahb(1'b0, svtd_pkg::ADDR_DWELL, 0);
    check(rd, 32'h0000_0004);
    ahb(1'b0, 8'h10, 0);
    check(rd, 32'h0000_0000);
    ahb(1'b0, svtd_pkg::ADDR_REMOTE, 0);
    check(rd, 32'h0000_0000);
    tick(50);
    check(32'(disp.msg), 32'(svtd_pkg::MSG_TEMP));
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      setf(tf[i], to[i], tq[i]);
      check(32'(disp.msg), 32'(tm[i]));
      check(32'(drive), 32'(td[i]));
    end
    $display("test messages done");
    setf(12'h303, 4'b1010, 0);
    setf(12'h203, 4'b1010, 0);
    check(32'(disp.msg), 32'(svtd_pkg::MSG_HE));
    check(32'(drive), 32'h0000_0001);
    setf(12'h201, 4'b1010, 0);
    setf(12'h203, 4'b1010, 0);
    check(32'(drive), 32'h0000_000D);
    setf(12'h303, 4'b1010, 0);
    setf(12'h203, 4'b1010, 0);
    ahb(1'b1, svtd_pkg::ADDR_REMOTE, 32'h0000_0002);
    tick(2);
    check(32'(disp.msg), 32'(svtd_pkg::MSG_TEMP));
    $display("test latch done");
    ahb(1'b1, svtd_pkg::ADDR_REMOTE, 32'h0000_0003);
    tick(2);
    check(32'(disp.msg), 32'(svtd_pkg::MSG_RSP));
    check(32'(drive), 32'h0000_0000);
    ahb(1'b1, svtd_pkg::ADDR_REMOTE, 32'h0000_0002);
    tick(2);
    check(32'(disp.msg), 32'(svtd_pkg::MSG_TEMP));
    ahb(1'b1, svtd_pkg::ADDR_REMOTE, 32'h0000_0001);
    setf(12'h202, 4'b0010, 0);
    setf(12'h203, 4'b0010, 0);
    check(32'(drive), 32'h0000_000D);
    $display("test remote done");
    run_tmain(30);
    ahb(1'b0, svtd_pkg::ADDR_ONTIME, 0);
    check(rd, 32'h0000_0003);
    hold_sel();
    keys <= 2'b11;
    wait_msg(svtd_pkg::MSG_RESET, CLR + 10);
    check(32'(n >= CLR), 32'd1);
    @(posedge hclk);
    keys <= 2'b00;
    ahb(1'b0, svtd_pkg::ADDR_ONTIME, 0);
    check(rd, 32'h0000_0000);
    wait_msg(svtd_pkg::MSG_TEMP, 20);
    $display("test clear done");
    run_tmain(30);
    run_tmain(14400);
    ahb(1'b0, svtd_pkg::ADDR_ONTIME, 0);
    check(rd, 32'h0001_0003);
    hold_sel();
    keys <= 2'b00;
    for (int k = 0; k < 7; k++) begin
      wait_msg(svtd_pkg::svtd_msg_t'(5'd18 + 5'(k)), 12);
      check(32'(disp.value), 32'(sv[k]));
      if (k > 0) begin
        check(32'(n), 32'd4);
      end
    end
    wait_msg(svtd_pkg::MSG_TEMP, 12);
    $display("test sequence done");
    conclude();
  end
endmodule : svtd_core_bench
`default_nettype wire
